// >>> hdl/acpmd_consts.svh
/*
  Offsets, field positions and reset values for the configuration pin decoder.
  Assumes inclusion by the decoder module only.
*/
// Functional notes
// [R1] Calibration flag high while calibration runs.
// [R2] Select pin high: pin-only control.
// [R3] Select pin low: extended control via registers.
// [R4] Dedicated select pin overrides shared-pin enable.
// [R5] Style pin high: single-ended reset, shared range select.
// [R6] Style pin low: differential reset pair.
// [R7] Differential mode forces the higher range.
// [R8] Extended control permits full-scale adjust writes.
// [R9] Shared pin low reduced, high higher range.
// [R10] Shared pin mid requests extended control.
// [R11] Extended: delay pin is chip select, short delay.
// [R12] Pins pass synchronisers before decoding.
`ifndef ACPMD_CONSTS_SVH
`define ACPMD_CONSTS_SVH
`define ACPMD_ADDR_CTRL 8'h00
`define ACPMD_ADDR_STATUS 8'h04
`define ACPMD_ADDR_BITS 8
`define ACPMD_FSADJ_RST 8'h80
`define ACPMD_ST_EXT 0
`define ACPMD_ST_DIFF 1
`define ACPMD_ST_RANGE_HIGH 2
`define ACPMD_ST_CAL 3
`define ACPMD_ST_CHIP_SEL 4
`define ACPMD_ST_DLY_LONG 5
`define ACPMD_ST_ALT_REQ 6
`define ACPMD_PIN_EXT_SEL_N 0
`define ACPMD_PIN_STYLE 1
`define ACPMD_PIN_SHARED 2
`define ACPMD_PIN_MID 3
`define ACPMD_PIN_RST_POS 4
`define ACPMD_PIN_DELAY_SEL 5
`define ACPMD_PIN_CALBUSY 6
`define ACPMD_NUM_PINS 7
`define ACPMD_SYNC_RST 7'h03
`endif

// >>> hdl/acpmd_decode.sv
/*
  Configuration pin decoder with an AHB-Lite register slave.
  Assumes pins are static straps or slow host levels, one clock domain,
  and a single AHB-Lite master issuing single word transfers.
*/
`timescale 1ns/1ps
`include "acpmd_consts.svh"
module acpmd_decode
  import acpmd_pkg::*;
#(
  parameter int FSADJ_W = 8,
  parameter int SYNC_STAGES = 2
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic extended_ctrl_select_n,
  input wire logic clock_reset_style_select,
  input wire logic full_scale_range_select,
  input wire logic shared_pin_mid,
  input wire logic output_clock_reset_pos,
  input wire logic calibration_delay_select,
  input wire logic calibration_in_progress,
  output logic calibration_active_flag,
  output logic extended_ctrl_active,
  output logic differential_reset_mode,
  output logic full_scale_range_high,
  output logic output_clock_reset,
  output logic serial_chip_select,
  output logic calibration_delay_long,
  output logic [FSADJ_W-1:0] full_scale_adjust
);

  // refuse widths the bus word cannot carry and other synchroniser depths
  if (FSADJ_W < 1 || FSADJ_W > 32 || SYNC_STAGES != 2)
  begin : g_param_check
    $error("acpmd_decode: unsupported parameter values");
  end

  localparam logic [`ACPMD_NUM_PINS-1:0] sync_rst_val = `ACPMD_SYNC_RST;

  logic [`ACPMD_NUM_PINS-1:0] pins_raw;
  logic [`ACPMD_NUM_PINS-1:0] sync1_ff;
  logic [`ACPMD_NUM_PINS-1:0] sync2_ff;
  logic ext_sel_n_s;
  logic style_s;
  logic shared_s;
  logic mid_s;
  logic rst_pos_s;
  logic delay_sel_s;
  logic calbusy_s;
  acpmd_rst_style_t nxt_style;
  logic nxt_ext;
  logic nxt_range_high;
  logic nxt_clk_reset;
  logic nxt_chip_sel;
  logic nxt_dly_long;
  logic alt_req;
  logic wr_pend_ff;
  logic [`ACPMD_ADDR_BITS-1:0] wr_addr_ff;
  logic addr_phase;
  logic [31:0] status_word;

  function automatic logic is_addr(input logic [31:0] a, input logic [7:0] off);
    is_addr = (a[31:`ACPMD_ADDR_BITS] == '0) && (a[`ACPMD_ADDR_BITS-1:0] == off);
  endfunction

  assign pins_raw = {calibration_in_progress, calibration_delay_select,
                     output_clock_reset_pos, shared_pin_mid,
                     full_scale_range_select, clock_reset_style_select,
                     extended_ctrl_select_n};

  // two-flop synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < `ACPMD_NUM_PINS; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          sync1_ff[gi] <= sync_rst_val[gi];
          sync2_ff[gi] <= sync_rst_val[gi];
        end
        else
        begin
          sync1_ff[gi] <= pins_raw[gi]; // see [R12]
          sync2_ff[gi] <= sync1_ff[gi]; // see [R12]
        end
      end
    end
  endgenerate

  assign ext_sel_n_s = sync2_ff[`ACPMD_PIN_EXT_SEL_N];
  assign style_s = sync2_ff[`ACPMD_PIN_STYLE];
  assign shared_s = sync2_ff[`ACPMD_PIN_SHARED];
  assign mid_s = sync2_ff[`ACPMD_PIN_MID];
  assign rst_pos_s = sync2_ff[`ACPMD_PIN_RST_POS];
  assign delay_sel_s = sync2_ff[`ACPMD_PIN_DELAY_SEL];
  assign calbusy_s = sync2_ff[`ACPMD_PIN_CALBUSY];

  always_comb
  begin
    // style pin floating reads high: single-ended
    nxt_style = style_s ? ACPMD_RST_SINGLE : ACPMD_RST_DIFF; // see [R5] see [R6]
    // shared pin asks for extended control only as alternate enable
    alt_req = (nxt_style == ACPMD_RST_SINGLE) && mid_s; // see [R10]
    // dedicated pin decides alone, overriding the shared request
    nxt_ext = !ext_sel_n_s; // see [R2] see [R3] see [R4]
    if (nxt_style == ACPMD_RST_DIFF)
      nxt_range_high = 1'b1; // see [R7]
    else if (mid_s)
      nxt_range_high = 1'b1;
    else
      nxt_range_high = shared_s; // see [R9]
    if (nxt_style == ACPMD_RST_DIFF)
      nxt_clk_reset = rst_pos_s && !shared_s; // see [R6]
    else
      nxt_clk_reset = rst_pos_s; // see [R5]
    if (nxt_ext)
    begin
      nxt_chip_sel = delay_sel_s; // see [R11]
      nxt_dly_long = 1'b0; // see [R11]
    end
    else
    begin
      nxt_chip_sel = 1'b1;
      nxt_dly_long = delay_sel_s;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      extended_ctrl_active <= 1'b0;
      differential_reset_mode <= 1'b0;
      full_scale_range_high <= 1'b1;
      output_clock_reset <= 1'b0;
      serial_chip_select <= 1'b1;
      calibration_delay_long <= 1'b0;
    end
    else
    begin
      extended_ctrl_active <= nxt_ext;
      differential_reset_mode <= (nxt_style == ACPMD_RST_DIFF);
      full_scale_range_high <= nxt_range_high;
      output_clock_reset <= nxt_clk_reset;
      serial_chip_select <= nxt_chip_sel;
      calibration_delay_long <= nxt_dly_long;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      calibration_active_flag <= 1'b0;
    else
      calibration_active_flag <= calbusy_s; // see [R1]
  end

  always_comb
  begin
    status_word = '0;
    status_word[`ACPMD_ST_EXT] = extended_ctrl_active;
    status_word[`ACPMD_ST_DIFF] = differential_reset_mode;
    status_word[`ACPMD_ST_RANGE_HIGH] = full_scale_range_high;
    status_word[`ACPMD_ST_CAL] = calibration_active_flag;
    status_word[`ACPMD_ST_CHIP_SEL] = serial_chip_select;
    status_word[`ACPMD_ST_DLY_LONG] = calibration_delay_long;
    status_word[`ACPMD_ST_ALT_REQ] = alt_req;
  end

  // zero-wait slave: accepted address phase of a single word transfer
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end
    else if (hready)
    begin
      wr_pend_ff <= addr_phase && hwrite;
      wr_addr_ff <= haddr[`ACPMD_ADDR_BITS-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      hrdata <= '0;
    else if (addr_phase && !hwrite)
    begin
      if (is_addr(haddr, `ACPMD_ADDR_CTRL))
        hrdata <= 32'(full_scale_adjust);
      else if (is_addr(haddr, `ACPMD_ADDR_STATUS))
        hrdata <= status_word;
      else
        hrdata <= '0;
    end
  end

  // adjust writes land only while extended control is active
  always_ff @(posedge clk)
  begin
    if (srst)
      full_scale_adjust <= FSADJ_W'(`ACPMD_FSADJ_RST);
    else if (wr_pend_ff && wr_addr_ff == `ACPMD_ADDR_CTRL && extended_ctrl_active)
      full_scale_adjust <= hwdata[FSADJ_W-1:0]; // see [R8]
  end

endmodule

// >>> hdl/acpmd_pkg.sv
/*
  Types shared by the configuration pin decoder.
  Assumes the constants header is on the include path.
*/
package acpmd_pkg;
  typedef enum logic [0:0] {
    ACPMD_RST_SINGLE = 1'b0,
    ACPMD_RST_DIFF = 1'b1
  } acpmd_rst_style_t;
endpackage

// >>> tb/acpmd_checker.sv
/* decoder output checks
   sees only the decoder ports */
`timescale 1ns/1ps
module acpmd_checker (
  input logic clk,
  input logic srst,
  input logic extended_ctrl_select_n,
  input logic clock_reset_style_select,
  input logic full_scale_range_select,
  input logic shared_pin_mid,
  input logic output_clock_reset_pos,
  input logic calibration_delay_select,
  input logic calibration_in_progress,
  input logic calibration_active_flag,
  input logic extended_ctrl_active,
  input logic differential_reset_mode,
  input logic full_scale_range_high,
  input logic output_clock_reset,
  input logic serial_chip_select,
  input logic calibration_delay_long
);
  logic [1:0] age_ff;
  logic [6:0] d1_ff, d2_ff, d3_ff;
  wire ok = age_ff == 2'h3;
  // outputs trail pins by three edges
  always_ff @(posedge clk)
    if (srst)
      age_ff <= 2'h0;
    else if (!ok)
      age_ff <= age_ff + 2'h1;
  always_ff @(posedge clk)
  begin
    d1_ff <= {calibration_in_progress, calibration_delay_select, output_clock_reset_pos,
      shared_pin_mid, full_scale_range_select, clock_reset_style_select, extended_ctrl_select_n};
    d2_ff <= d1_ff;
    d3_ff <= d2_ff;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_cal_flag_tracks: assert property (ok |-> calibration_active_flag == d3_ff[6])
    else $error("cal flag wrong");
  a_pin_only_mode: assert property (ok && d3_ff[0] |-> !extended_ctrl_active)
    else $error("ext on");
  a_ext_mode_on: assert property (ok && !d3_ff[0] |-> extended_ctrl_active)
    else $error("ext off");
  a_shared_no_ext: assert property (ok && d3_ff[0] && d3_ff[3] |-> !extended_ctrl_active)
    else $error("shared overrode");
  a_style_decode: assert property (ok |-> differential_reset_mode != d3_ff[1])
    else $error("style wrong");
  a_single_reset: assert property (ok && d3_ff[1] |-> output_clock_reset == d3_ff[4])
    else $error("single reset wrong");
  a_diff_reset: assert property (ok && !d3_ff[1] |->
    output_clock_reset == (d3_ff[4] && !d3_ff[2]))
    else $error("diff reset wrong");
  a_diff_range_high: assert property (ok && differential_reset_mode |-> full_scale_range_high)
    else $error("range not high");
  a_range_level: assert property (ok && d3_ff[1] && !d3_ff[3] |->
    full_scale_range_high == d3_ff[2])
    else $error("range wrong");
  a_chip_select: assert property (ok && !d3_ff[0] |->
    serial_chip_select == d3_ff[5] && !calibration_delay_long)
    else $error("chip select wrong");
endmodule
bind acpmd_decode acpmd_checker chk (.*);

// >>> tb/acpmd_decode_test.sv
/* bench for the pin decoder
   straps via model, registers over AHB-Lite */
`timescale 1ns/1ps
module acpmd_decode_test;
  logic clk, srst, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] want, adj, fsa;
  logic [6:0] pins, o, e;
  logic [7:0] vecs [6] = '{8'h73, 8'h85, 8'h10, 8'h34, 8'h0B, 8'h26};
  int fail_count, compares;
  acpmd_decode uut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .extended_ctrl_select_n(pins[0]), .clock_reset_style_select(pins[1]),
    .full_scale_range_select(pins[2]), .shared_pin_mid(pins[3]),
    .output_clock_reset_pos(pins[4]), .calibration_delay_select(pins[5]),
    .calibration_in_progress(pins[6]), .calibration_active_flag(o[6]),
    .extended_ctrl_active(o[5]), .differential_reset_mode(o[4]),
    .full_scale_range_high(o[3]), .output_clock_reset(o[2]),
    .serial_chip_select(o[1]), .calibration_delay_long(o[0]), .full_scale_adjust(fsa));
  acpmd_strap strap (.clk(clk), .want(want), .pins(pins));
  assign hready = hreadyout;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  function automatic logic [6:0] pred(input logic [7:0] v);
    logic ext, dif;
    ext = !v[0];
    dif = !(v[1] | v[7]);
    return {v[6], ext, dif, dif | v[3] | v[2], v[4] & !(dif & v[2]), !ext | v[5], !ext & v[5]};
  endfunction
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
    begin
      fail_count++;
      tally_and_finish;
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask
  initial
  begin
    fail_count = 0;
    compares = 0;
    {srst, hsel, htrans, haddr, hwrite, hwdata} = {4'h8, 65'h0};
    want = 8'h03;
    adj = 8'h80;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    cmp(32'(o), 32'h0A);
    foreach (vecs[i])
    begin
      want <= vecs[i];
      repeat (5) @(posedge clk);
      e = pred(vecs[i]);
      cmp(32'(o), 32'(e));
      cmp(32'(o[6:5]), 32'(e[6:5]));
      xfer(1'b1, 32'h0, {24'h0, ~vecs[i]});
      if (e[5])
        adj = ~vecs[i];
      xfer(1'b0, 32'h0, 32'h0);
      cmp(rd, {24'h0, adj});
      cmp(32'(fsa), 32'(adj));
      xfer(1'b1, 32'h4, 32'hFFFFFFFF);
      xfer(1'b0, 32'h4, 32'h0);
      cmp(rd, {25'h0, !e[4] & vecs[i][3], e[0], e[1], e[6], e[3], e[4], e[5]});
      cmp({31'h0, hresp}, 32'h0);
    end
    xfer(1'b1, 32'h8, 32'h0);
    xfer(1'b0, 32'h8, 32'h0);
    cmp(rd, 32'h0);
    xfer(1'b0, 32'h0, 32'h0);
    cmp(rd, {24'h0, adj});
    tally_and_finish;
  end
endmodule

// >>> tb/acpmd_strap.sv
/* board strap model
   want: [7] style floats, [3] shared floats */
`timescale 1ns/1ps
module acpmd_strap (
  input logic clk,
  input logic [7:0] want,
  output logic [6:0] pins = 7'h03
);
  always @(posedge clk)
  begin
    pins[1:0] <= {want[7] | want[1], want[0]};
    // floating shared pin has no stable level
    pins[2] <= want[3] ? !pins[2] : want[2];
    pins[6:3] <= want[6:3];
  end
endmodule
